// File: hw/qpvr_top.sv
// Summary of operation
// (RULE1) Full scale is 100h, or 80h on 7-bit.
// (RULE2) Reset pin low holds defaults, serial disabled.
// (RULE3) Pull-ups on while supply low or reset.
// (RULE4) Supply rising loads defaults, then enables operation.
// (RULE5) Supply below trip disables serial, ignores commands.
// (RULE6) Brown-out recovery repeats the power-on sequence.
// (RULE7) Sixteen volatile locations, nine bits each.
// (RULE8) Wipers 0,1 at 00h,01h, all commands.
// (RULE9) Wipers 2,3 at 06h,07h, all commands.
// (RULE10) Terminal controls at 04h,0Ah: read, write only.
// (RULE11) Other addresses reserved; every command disallowed.
// (RULE12) Wiper default is mid-scale: 80h or 40h.
// (RULE13) Read data and error flag reach the host.
// (RULE14) Disallowed command sets error; chip-select cycle clears.
// (RULE15) Terminal controls reset to 1FFh, all connected.
// (RULE16) Terminal control applies after its command completes.
// (RULE17) Increment and decrement saturate, never wrap.
`include "qpvr_defines.svh"

module qpvr_top #(
    parameter bit EIGHT_BIT = 1'b1                            // 1: 8-bit, 0: 7-bit
) (
    input  wire logic              CLOCK_IN,                  // 200 MHz clock
    input  wire logic              RST_IN,                    // Async reset, high
    input  wire logic              RESET_N_IN,                // Reset pin, low
    input  wire logic              SUPPLY_OK_IN,              // Supply above trip
    input  wire logic              CS_N_IN,                   // Chip select pin, low
    input  wire qpvr_pkg::qpvr_cmd_t CMD_IN,                  // Completed command
    output logic                   SERIAL_EN_OUT,             // Serial port enabled
    output logic                   PULLUP_EN_OUT,             // Weak pull-ups on
    output logic                   ERROR_OUT,                 // Command error flag
    output qpvr_pkg::qpvr_rd_t     RD_OUT,                    // Read answer
    output logic [3:0][8:0]        WIPER_OUT,                 // Wiper codes 0..3
    output logic [1:0][8:0]        TERM_CTRL_OUT              // Applied term controls
);
    import qpvr_pkg::*;

    // ======================================================================
    // Pin synchronisers.
    // ======================================================================
    logic [2:0] meta_q;
    logic [2:0] meta_d;
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic       cs_prev_q;
    logic       cs_prev_d;
    logic       rst_pin_n;
    logic       supply_ok;
    logic       cs_n;

    always_comb begin
        meta_d    = {CS_N_IN, SUPPLY_OK_IN, RESET_N_IN};
        sync_d    = meta_q;
        cs_prev_d = sync_q[2];
    end

    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            meta_q    <= `QPVR_SYNC_RESET;
            sync_q    <= `QPVR_SYNC_RESET;
            cs_prev_q <= 1'b1;
        end else begin
            meta_q    <= meta_d;
            sync_q    <= sync_d;
            cs_prev_q <= cs_prev_d;
        end
    end

    assign rst_pin_n = sync_q[0];
    assign supply_ok = sync_q[1];
    assign cs_n      = sync_q[2];

    // ======================================================================
    // Reset sequencing.
    // ======================================================================
    typedef enum logic [1:0] {
        ST_HOLD,
        ST_LOAD,
        ST_RUN
    } qpvr_state_t;

    qpvr_state_t state_q;
    qpvr_state_t state_d;
    logic        hold_cond;

    always_comb begin
        // Either source alone holds the device in its reset state.
        hold_cond = !supply_ok || !rst_pin_n;                          // RULE2 RULE5
        state_d   = state_q;
        case (state_q)
            ST_HOLD: if (!hold_cond) state_d = ST_LOAD;                // RULE4 RULE6
            ST_LOAD: state_d = hold_cond ? ST_HOLD : ST_RUN;           // RULE4
            ST_RUN:  if (hold_cond) state_d = ST_HOLD;                 // RULE5 RULE2
            default: state_d = ST_HOLD;
        endcase
    end

    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_q <= ST_HOLD;
        end else begin
            state_q <= state_d;
        end
    end

    // ======================================================================
    // Register array and command execution.
    // ======================================================================
    logic [8:0] mem_q [`QPVR_LOCATIONS];
    logic [8:0] mem_d [`QPVR_LOCATIONS];
    logic [8:0] mid_code;
    logic [8:0] full_code;
    logic       exec_allowed;
    logic       exec_update;
    logic [8:0] exec_new;
    logic       run;
    logic       accept;
    logic       err_q;
    logic       err_d;
    qpvr_rd_t   rd_q;
    qpvr_rd_t   rd_d;

    assign mid_code  = EIGHT_BIT ? `QPVR_MID_8BIT : `QPVR_MID_7BIT;    // RULE12
    assign full_code = EIGHT_BIT ? `QPVR_FULL_8BIT : `QPVR_FULL_7BIT;  // RULE1
    assign run       = (state_q == ST_RUN);
    // A pending error blocks further commands until chip select is cycled.
    assign accept    = run && CMD_IN.valid && !err_q;                  // RULE5 RULE14

    qpvr_cmd_exec u_exec (
        .op_in       (CMD_IN.op),
        .addr_in     (CMD_IN.addr),
        .cur_in      (mem_q[CMD_IN.addr]),
        .wdata_in    (CMD_IN.data),
        .full_in     (full_code),
        .allowed_out (exec_allowed),
        .update_out  (exec_update),
        .new_out     (exec_new)
    );

    always_comb begin
        for (int i = 0; i < `QPVR_LOCATIONS; i++) begin
            mem_d[i] = mem_q[i];                                       // RULE7
        end
        rd_d = '{valid: 1'b0, data: `QPVR_ZERO};
        if (!run) begin
            // Defaults are driven through hold and the load step alike.
            for (int i = 0; i < `QPVR_LOCATIONS; i++) begin
                mem_d[i] = `QPVR_ZERO;
            end
            mem_d[`QPVR_ADDR_WIPER0] = mid_code;                       // RULE2 RULE4 RULE12
            mem_d[`QPVR_ADDR_WIPER1] = mid_code;                       // RULE6
            mem_d[`QPVR_ADDR_WIPER2] = mid_code;
            mem_d[`QPVR_ADDR_WIPER3] = mid_code;
            mem_d[`QPVR_ADDR_TCTRL0] = `QPVR_TCTRL_RESET;              // RULE15
            mem_d[`QPVR_ADDR_TCTRL1] = `QPVR_TCTRL_RESET;              // RULE15
        end else if (accept && exec_allowed) begin
            if (exec_update) begin
                mem_d[CMD_IN.addr] = exec_new;
            end
            if (CMD_IN.op == QPVR_OP_READ) begin
                rd_d = '{valid: 1'b1, data: mem_q[CMD_IN.addr]};       // RULE13
            end
        end
    end

    always_comb begin
        err_d = err_q;
        if (!run) begin
            err_d = 1'b0;
        end else begin
            if (cs_n && !cs_prev_q) begin
                err_d = 1'b0;                                          // RULE14
            end
            // A new fault in the clearing cycle still wins.
            if (accept && !exec_allowed) begin
                err_d = 1'b1;                                          // RULE14 RULE10 RULE11
            end
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            for (int i = 0; i < `QPVR_LOCATIONS; i++) begin
                mem_q[i] <= `QPVR_ZERO;
            end
            mem_q[`QPVR_ADDR_WIPER0] <= `QPVR_MID_8BIT;
            mem_q[`QPVR_ADDR_WIPER1] <= `QPVR_MID_8BIT;
            mem_q[`QPVR_ADDR_WIPER2] <= `QPVR_MID_8BIT;
            mem_q[`QPVR_ADDR_WIPER3] <= `QPVR_MID_8BIT;
            mem_q[`QPVR_ADDR_TCTRL0] <= `QPVR_TCTRL_RESET;
            mem_q[`QPVR_ADDR_TCTRL1] <= `QPVR_TCTRL_RESET;
            err_q <= 1'b0;
            rd_q  <= '0;
        end else begin
            mem_q <= mem_d;
            err_q <= err_d;
            rd_q  <= rd_d;
        end
    end

    // ======================================================================
    // Output registers.
    // ======================================================================
    logic [3:0][8:0] wiper_d;
    logic [1:0][8:0] tctrl_d;

    always_comb begin
        wiper_d[0] = mem_q[`QPVR_ADDR_WIPER0];                         // RULE8
        wiper_d[1] = mem_q[`QPVR_ADDR_WIPER1];
        wiper_d[2] = mem_q[`QPVR_ADDR_WIPER2];                         // RULE9
        wiper_d[3] = mem_q[`QPVR_ADDR_WIPER3];
        // Sampled from the stored value, so the network sees it only
        // after the command that wrote it has been fully executed.
        tctrl_d[0] = mem_q[`QPVR_ADDR_TCTRL0];                         // RULE16
        tctrl_d[1] = mem_q[`QPVR_ADDR_TCTRL1];
    end

    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            SERIAL_EN_OUT <= 1'b0;
            PULLUP_EN_OUT <= 1'b1;
            ERROR_OUT     <= 1'b0;
            RD_OUT        <= '0;
            WIPER_OUT     <= {4{`QPVR_MID_8BIT}};
            TERM_CTRL_OUT <= {2{`QPVR_TCTRL_RESET}};
        end else begin
            SERIAL_EN_OUT <= run;                                      // RULE2 RULE5
            PULLUP_EN_OUT <= hold_cond;                                // RULE3
            ERROR_OUT     <= err_q;                                    // RULE13
            RD_OUT        <= rd_q;                                     // RULE13
            WIPER_OUT     <= wiper_d;
            TERM_CTRL_OUT <= tctrl_d;
        end
    end

endmodule

// File: hw/qpvr_defines.svh
`ifndef QPVR_DEFINES_SVH
`define QPVR_DEFINES_SVH

// ==========================================================================
// Register map and field layout.
// ==========================================================================
`define QPVR_DATA_W        9
`define QPVR_ADDR_W        4
`define QPVR_LOCATIONS     16
`define QPVR_ADDR_WIPER0   4'h0
`define QPVR_ADDR_WIPER1   4'h1
`define QPVR_ADDR_TCTRL0   4'h4
`define QPVR_ADDR_WIPER2   4'h6
`define QPVR_ADDR_WIPER3   4'h7
`define QPVR_ADDR_TCTRL1   4'ha
`define QPVR_TCTRL_FIXED   8
// Synchronisers start as chip select idle, supply low and reset pin low.
`define QPVR_SYNC_RESET    3'h4

// ==========================================================================
// Codes: defaults, full scale and zero scale.
// ==========================================================================
`define QPVR_MID_8BIT      9'h080
`define QPVR_MID_7BIT      9'h040
`define QPVR_FULL_8BIT     9'h100
`define QPVR_FULL_7BIT     9'h080
`define QPVR_ZERO          9'h000
`define QPVR_TCTRL_RESET   9'h1ff
`define QPVR_ONE           9'h001

`endif

// File: hw/qpvr_pkg.sv
`include "qpvr_defines.svh"

package qpvr_pkg;

    typedef enum logic [1:0] {
        QPVR_OP_WRITE,
        QPVR_OP_INC,
        QPVR_OP_DEC,
        QPVR_OP_READ
    } qpvr_op_t;

    typedef enum logic [1:0] {
        QPVR_KIND_WIPER,
        QPVR_KIND_TCTRL,
        QPVR_KIND_RSVD
    } qpvr_kind_t;

    // One completed serial command, handed over by the serial framer.
    typedef struct packed {
        logic       valid;
        qpvr_op_t   op;
        logic [3:0] addr;
        logic [8:0] data;
    } qpvr_cmd_t;

    typedef struct packed {
        logic       valid;
        logic [8:0] data;
    } qpvr_rd_t;

    function automatic qpvr_kind_t qpvr_decode(input logic [3:0] addr);
        case (addr)
            `QPVR_ADDR_WIPER0,
            `QPVR_ADDR_WIPER1,
            `QPVR_ADDR_WIPER2,
            `QPVR_ADDR_WIPER3:  qpvr_decode = QPVR_KIND_WIPER;
            `QPVR_ADDR_TCTRL0,
            `QPVR_ADDR_TCTRL1:  qpvr_decode = QPVR_KIND_TCTRL;
            default:                qpvr_decode = QPVR_KIND_RSVD;
        endcase
    endfunction

endpackage

// File: hw/qpvr_cmd_exec.sv
`include "qpvr_defines.svh"

module qpvr_cmd_exec
    import qpvr_pkg::*;
(
    input  wire qpvr_pkg::qpvr_op_t op_in,        // Command operation
    input  wire logic [3:0]         addr_in,      // Target location
    input  wire logic [8:0]         cur_in,       // Present register value
    input  wire logic [8:0]         wdata_in,     // Write data
    input  wire logic [8:0]         full_in,      // Full-scale code of variant
    output logic                    allowed_out,  // Command legal at address
    output logic                    update_out,   // Register takes new_out
    output logic [8:0]              new_out       // Next register value
);

    qpvr_kind_t kind;

    always_comb begin
        kind        = qpvr_decode(addr_in);
        allowed_out = 1'b0;
        update_out  = 1'b0;
        new_out     = cur_in;
        case (kind)
            QPVR_KIND_WIPER: begin
                allowed_out = 1'b1;                                    // RULE8 RULE9
                case (op_in)
                    QPVR_OP_WRITE: begin
                        update_out = 1'b1;
                        // Codes past full scale have no tap, so they clamp.
                        new_out = (wdata_in > full_in) ? full_in : wdata_in;
                    end
                    QPVR_OP_INC: begin
                        update_out = 1'b1;
                        if (cur_in < full_in) begin                    // RULE17 RULE1
                            new_out = 9'(cur_in + `QPVR_ONE);
                        end
                    end
                    QPVR_OP_DEC: begin
                        update_out = 1'b1;
                        if (cur_in != `QPVR_ZERO) begin                // RULE17
                            new_out = 9'(cur_in - `QPVR_ONE);
                        end
                    end
                    default: update_out = 1'b0;
                endcase
            end
            QPVR_KIND_TCTRL: begin
                case (op_in)
                    QPVR_OP_WRITE: begin
                        allowed_out = 1'b1;                            // RULE10
                        update_out  = 1'b1;
                        new_out     = wdata_in;
                        new_out[`QPVR_TCTRL_FIXED] = 1'b1;
                    end
                    QPVR_OP_READ: allowed_out = 1'b1;                  // RULE10
                    default:      allowed_out = 1'b0;                  // RULE10
                endcase
            end
            default: allowed_out = 1'b0;                               // RULE11
        endcase
    end

endmodule

// File: test/qpvr_top_props.sv
module qpvr_top_props
    import qpvr_pkg::*;
#(
    parameter bit EIGHT_BIT = 1'b1 // 1: 8-bit variant
) (
    input wire logic                CLOCK_IN,      // Clock
    input wire logic                RST_IN,        // Reset
    input wire logic                RESET_N_IN,    // Reset pin
    input wire logic                SUPPLY_OK_IN,  // Supply good
    input wire logic                CS_N_IN,       // Chip select
    input wire qpvr_pkg::qpvr_cmd_t CMD_IN,        // Command
    input wire logic                SERIAL_EN_OUT, // Serial enabled
    input wire logic                PULLUP_EN_OUT, // Pull-ups on
    input wire logic                ERROR_OUT,     // Error flag
    input wire qpvr_pkg::qpvr_rd_t  RD_OUT,        // Read answer
    input wire logic [3:0][8:0]     WIPER_OUT,     // Wipers
    input wire logic [1:0][8:0]     TERM_CTRL_OUT  // Term controls
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [8:0] FULL = EIGHT_BIT ? 9'h100 : 9'h080;
    localparam logic [8:0] MID = EIGHT_BIT ? 9'h080 : 9'h040;
    logic [4:0] hist_q;
    logic [4:0] hist_d;
    logic       ok;
    logic       ready;
    logic       tsel;
    logic       mapped;
    assign ok = RESET_N_IN & SUPPLY_OK_IN;
    assign tsel = CMD_IN.addr == 4'h4 || CMD_IN.addr == 4'ha;
    assign mapped = tsel || CMD_IN.addr inside {4'h0, 4'h1, 4'h6, 4'h7};
    // Only judge commands once the pins were quiet and no earlier command can still move the flag.
    assign ready = SERIAL_EN_OUT && !ERROR_OUT && ok && &hist_q[4:2] && !(|hist_q[1:0]);
    always_comb begin
        hist_d = {hist_q[3:2], ok, hist_q[0], CMD_IN.valid};
    end
    always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            hist_q <= 5'h00;
        end else begin
            hist_q <= hist_d;
        end
    end
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RST_IN);
    property p_rd_lat;
        ready && CMD_IN.valid && CMD_IN.op == QPVR_OP_READ && mapped |-> ##2 RD_OUT.valid;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_tctrl;
        ready && CMD_IN.valid && CMD_IN.op == QPVR_OP_WRITE && CMD_IN.addr == 4'ha
            |-> ##2 TERM_CTRL_OUT[1] == {1'b1, $past(CMD_IN.data[7:0], 2)};
    endproperty
    a_tctrl: assert property (p_tctrl) else $error("term control not applied");
    property p_inc_sat;
        ready && CMD_IN.valid && CMD_IN.op == QPVR_OP_INC && CMD_IN.addr == 4'h0
            && WIPER_OUT[0] == FULL |-> ##1 (WIPER_OUT[0] == FULL) [*2];
    endproperty
    a_inc_sat: assert property (p_inc_sat) else $error("wiper wrapped");
    property p_err_set;
        ready && CMD_IN.valid && (!mapped || (tsel && CMD_IN.op inside {QPVR_OP_INC, QPVR_OP_DEC}))
            |-> ##2 ERROR_OUT;
    endproperty
    a_err_set: assert property (p_err_set) else $error("error not raised");
    property p_err_clr;
        $rose(CS_N_IN) && ERROR_OUT ##1 (!CMD_IN.valid) [*3] |-> ##1 !ERROR_OUT;
    endproperty
    a_err_clr: assert property (p_err_clr) else $error("error not cleared");
    property p_hold;
        !ok |-> ##3 PULLUP_EN_OUT ##1 !SERIAL_EN_OUT;
    endproperty
    a_hold: assert property (p_hold) else $error("serial still enabled");
    property p_hold_def;
        (!ok) [*2] |-> ##4 WIPER_OUT[2] == MID && TERM_CTRL_OUT[1] == 9'h1ff;
    endproperty
    a_hold_def: assert property (p_hold_def) else $error("defaults not loaded");
    property p_release;
        ok [*7] |-> SERIAL_EN_OUT && !PULLUP_EN_OUT;
    endproperty
    a_release: assert property (p_release) else $error("not enabled");
endmodule

bind qpvr_top qpvr_top_props #(.EIGHT_BIT(EIGHT_BIT)) u_props (.CLOCK_IN(CLOCK_IN),
    .RST_IN(RST_IN), .RESET_N_IN(RESET_N_IN), .SUPPLY_OK_IN(SUPPLY_OK_IN),
    .CS_N_IN(CS_N_IN), .CMD_IN(CMD_IN), .SERIAL_EN_OUT(SERIAL_EN_OUT),
    .PULLUP_EN_OUT(PULLUP_EN_OUT), .ERROR_OUT(ERROR_OUT), .RD_OUT(RD_OUT),
    .WIPER_OUT(WIPER_OUT), .TERM_CTRL_OUT(TERM_CTRL_OUT));

// File: test/qpvr_host.sv
module qpvr_host
    import qpvr_pkg::*;
(
    input  wire logic          clk_in,  // Device clock
    output qpvr_pkg::qpvr_cmd_t cmd_out, // Command to device
    output logic               cs_n_out // Chip select, low
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_out = '0;
        cs_n_out = 1'b0;
    end
    // Idle cycles clear valid and invert address and data so a stale command can never look valid.
    task automatic send(input qpvr_op_t op, input logic [3:0] a, input logic [8:0] d);
        @(negedge clk_in);
        cmd_out <= '{1'b1, op, a, d};
        @(negedge clk_in);
        cmd_out <= '{1'b0, op, ~a, ~d};
    endtask
    task automatic cs_cycle();
        @(negedge clk_in);
        cs_n_out <= 1'b1;
        repeat (4) @(negedge clk_in);
        cs_n_out <= 1'b0;
    endtask
endmodule

// File: test/qpvr_test.sv
module quad_pot_volatile_regs_reset_test;
    timeunit 1ns;
    timeprecision 1ps;
    import qpvr_pkg::*;
    logic            clk, rst, reset_n, supply_ok, cs_n, serial_en, pullup_en, error;
    qpvr_cmd_t       cmd;
    qpvr_rd_t        rd;
    logic [3:0][8:0] wiper;
    logic [3:0][8:0] wiper7;
    logic [1:0][8:0] term;
    int              n_errors = 0;
    int              comparisons = 0;
    localparam logic [3:0] WADDR [4] = '{4'h0, 4'h1, 4'h6, 4'h7};
    localparam logic [3:0] RSV [10] = '{4'h2, 4'h3, 4'h5, 4'h8, 4'h9,
                                         4'hb, 4'hc, 4'hd, 4'he, 4'hf};
    qpvr_top dut (.CLOCK_IN(clk), .RST_IN(rst), .RESET_N_IN(reset_n), .SUPPLY_OK_IN(supply_ok),
        .CS_N_IN(cs_n), .CMD_IN(cmd), .SERIAL_EN_OUT(serial_en), .PULLUP_EN_OUT(pullup_en),
        .ERROR_OUT(error), .RD_OUT(rd), .WIPER_OUT(wiper), .TERM_CTRL_OUT(term));
    // The 7-bit variant follows the same command stream; only its wipers are compared.
    qpvr_top #(.EIGHT_BIT(1'b0)) dut_7bit (.CLOCK_IN(clk), .RST_IN(rst), .RESET_N_IN(reset_n),
        .SUPPLY_OK_IN(supply_ok), .CS_N_IN(cs_n), .CMD_IN(cmd), .SERIAL_EN_OUT(),
        .PULLUP_EN_OUT(), .ERROR_OUT(), .RD_OUT(), .WIPER_OUT(wiper7), .TERM_CTRL_OUT());
    qpvr_host host (.clk_in(clk), .cmd_out(cmd), .cs_n_out(cs_n));
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic do_cmd(input qpvr_op_t op, input logic [3:0] a, input logic [8:0] d);
        host.send(op, a, d);
        repeat (2) @(negedge clk);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [8:0] exp);
        int i;
        host.send(QPVR_OP_READ, a, 9'h000);
        for (i = 0; i < 4 && rd.valid !== 1'b1; i++) @(negedge clk);
        check(rd.valid, 1'b1);
        check(rd.data, exp);
    endtask
    task automatic wait_en();
        int i;
        for (i = 0; i < 12 && serial_en !== 1'b1; i++) @(negedge clk);
        check(serial_en, 1'b1);
        check(pullup_en, 1'b0);
    endtask
    task automatic clear_err();
        host.cs_cycle();
        @(negedge clk);
        check(error, 1'b0);
    endtask
    task automatic final_report();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #20us;
        n_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        final_report();
    end
    initial begin
        int k;
        rst = 1'b1;
        reset_n = 1'b1;
        supply_ok = 1'b1;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        wait_en();
        check(error, 1'b0);
        check(wiper7[2], 9'h040);
        for (k = 0; k < 4; k++) rd_chk(WADDR[k], 9'h080);
        rd_chk(4'h4, 9'h1ff);
        rd_chk(4'ha, 9'h1ff);
        for (k = 0; k < 4; k++) begin
            do_cmd(QPVR_OP_WRITE, WADDR[k], 9'h0a0 + 9'(k));
            check(wiper[k], 9'h0a0 + 9'(k));
        end
        do_cmd(QPVR_OP_WRITE, 4'h0, 9'h100);
        do_cmd(QPVR_OP_INC, 4'h0, 9'h000);
        check(wiper[0], 9'h100);
        check(wiper7[0], 9'h080);
        do_cmd(QPVR_OP_DEC, 4'h0, 9'h000);
        check(wiper[0], 9'h0ff);
        check(wiper7[0], 9'h07f);
        do_cmd(QPVR_OP_WRITE, 4'h1, 9'h000);
        do_cmd(QPVR_OP_DEC, 4'h1, 9'h000);
        check(wiper[1], 9'h000);
        do_cmd(QPVR_OP_INC, 4'h7, 9'h000);
        check(wiper[3], 9'h0a4);
        do_cmd(QPVR_OP_WRITE, 4'h4, 9'h0a5);
        check(term[0], 9'h1a5);
        do_cmd(QPVR_OP_WRITE, 4'ha, 9'h05a);
        check(term[1], 9'h15a);
        do_cmd(QPVR_OP_INC, 4'h4, 9'h000);
        check(error, 1'b1);
        do_cmd(QPVR_OP_WRITE, 4'h0, 9'h011);
        check(wiper[0], 9'h0ff);
        clear_err();
        do_cmd(QPVR_OP_DEC, 4'ha, 9'h000);
        check(term[1], 9'h15a);
        check(error, 1'b1);
        clear_err();
        for (k = 0; k < 10; k++) begin
            do_cmd(qpvr_op_t'(k[1:0]), RSV[k], 9'h000);
            check(error, 1'b1);
            clear_err();
        end
        for (k = 0; k < 2; k++) begin
            do_cmd(QPVR_OP_WRITE, 4'h6, 9'h033);
            do_cmd(QPVR_OP_WRITE, 4'ha, 9'h000);
            reset_n = (k != 0);
            supply_ok = (k == 0);
            repeat (6) @(negedge clk);
            check(serial_en, 1'b0);
            check(pullup_en, 1'b1);
            check(term[1], 9'h1ff);
            do_cmd(QPVR_OP_WRITE, 4'h6, 9'h055);
            check(wiper[2], 9'h080);
            reset_n = 1'b1;
            supply_ok = 1'b1;
            wait_en();
            check(wiper[2], 9'h080);
            check(wiper7[2], 9'h040);
        end
        final_report();
    end
endmodule
